// *** rtl/rld_consts.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef RLD_CONSTS_SVH
`define RLD_CONSTS_SVH

// byte offsets on the register bus
`define RLD_ADR_STATUS      8'h00
`define RLD_ADR_LOSS_CTRL   8'h04
`define RLD_ADR_RXOUT_CTRL  8'h08

// loss_detect_control fields
`define RLD_CR2_EQ_EN       0
`define RLD_CR2_DENS_DIS    1
`define RLD_CR2_AMP_DIS     2
`define RLD_CR2_RST         3'h0

// receive_output_control fields (bit 0 reserved)
`define RLD_CR3_CLK_INV     1
`define RLD_CR3_SHUTOFF     2
`define RLD_CR3_MUTE        3
`define RLD_CR3_SINGLE_RAIL 4
`define RLD_CR3_RST         4'h0

// timing in unit intervals of the recovered clock, plus density ones per window and good-window count
`define RLD_ALOS_LAST_UI    6'h1F
`define RLD_DENS_ZERO_RUN   8'hA0
`define RLD_DENS_WIN_LAST   5'h1F
`define RLD_DENS_WIN_ONES   6'h0A
`define RLD_DENS_GOOD_LAST  2'h3

`endif

// *** rtl/rld_pkg.sv ***
// types and shared arithmetic of the loss-of-signal block
package rld_pkg;

  typedef enum logic {DENS_NORMAL, DENS_LOST} rld_dens_e;
  typedef enum logic {ALOS_CLEAR, ALOS_LOST} rld_alos_e;

  function automatic logic [7:0] rld_sat_inc8(input logic [7:0] v);
    rld_sat_inc8 = (v == 8'hFF) ? v : v + 8'h01;
  endfunction : rld_sat_inc8

endpackage : rld_pkg

// *** rtl/rld_sync.sv ***
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module rld_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : rld_sync

// *** rtl/rld_density.sv ***
// pulse-density loss detector: zero-run declare, window-based clear
`timescale 1ns/1ps
`include "rld_consts.svh"
module rld_density
  import rld_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // one strobe per unit interval with the bit value
  input  wire logic bit_en_i,
  input  wire logic bit_one_i,
  input  wire logic disable_i,
  // state
  output logic      density_loss_o
);

  rld_dens_e   state_r;
  logic [7:0]  zero_cnt_r;
  logic [4:0]  win_bit_r;
  logic [5:0]  win_ones_r;
  logic [1:0]  good_r;

  wire  [7:0]  zero_nxt  = rld_sat_inc8(zero_cnt_r);
  wire  [5:0]  ones_nxt  = win_ones_r + {5'h00, bit_one_i};
  wire         win_end   = (win_bit_r == `RLD_DENS_WIN_LAST);
  wire         win_good  = (ones_nxt >= `RLD_DENS_WIN_ONES);
  wire         run_hit   = !bit_one_i && (zero_nxt == `RLD_DENS_ZERO_RUN);

  assign density_loss_o = (state_r == DENS_LOST);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r    <= DENS_NORMAL;
      zero_cnt_r <= 8'h00;
      win_bit_r  <= 5'h00;
      win_ones_r <= 6'h00;
      good_r     <= 2'h0;
    end else if (disable_i) begin
      state_r    <= DENS_NORMAL;
      zero_cnt_r <= 8'h00;
    end else if (bit_en_i) begin
      case (state_r)
        DENS_NORMAL: begin
          zero_cnt_r <= bit_one_i ? 8'h00 : zero_nxt;
          win_bit_r  <= 5'h00;
          win_ones_r <= 6'h00;
          good_r     <= 2'h0;
          if (run_hit) state_r <= DENS_LOST;
        end
        DENS_LOST: begin
          win_bit_r  <= win_bit_r + 5'h01;
          win_ones_r <= win_end ? 6'h00 : ones_nxt;
          if (win_end && !win_good) good_r <= 2'h0;
          else if (win_end && good_r != `RLD_DENS_GOOD_LAST)
            good_r <= good_r + 2'h1;
          else if (win_end) begin
            state_r    <= DENS_NORMAL;
            zero_cnt_r <= 8'h00;
          end
        end
        default: state_r <= DENS_NORMAL;
      endcase
    end
  end

endmodule : rld_density

// *** rtl/rld_los_detect.sv ***
// receive loss-of-signal supervision and dual-rail output stage
//
// Function
// - declare loss between 10 and 255 unit intervals after signal is lost
// - clear loss between 10 and 255 unit intervals after signal returns
// - combined loss is the OR of amplitude loss and density loss
// - set amplitude loss once amplitude falls to the declare threshold
// - clear amplitude loss only above the higher clear threshold
// - status reports lock, combined, amplitude, density, drive monitor
// - amplitude status bit reads one exactly while amplitude loss declared
// - control bit 2 set disables the amplitude-loss detector
// - control bit 1 set disables the density-loss detector
// - with both detectors disabled loss is never declared
// - declare density loss on a zero run of 160, tolerance 32
// - clear density loss after four 32-bit windows of ten ones each
// - with muting on, force both rails low while loss is declared
// - hardware mode: mute pin high enables muting
// - host mode: output-control bit 3 enables muting
// - rails change on rising recovered clock when not inverted
// - positive pulse drives positive rail, negative drives negative rail
// - recovered clock is forwarded at the line rate
// - hardware mode: invert pin high launches data on the falling edge
// - host mode: output-control bit 1 inverts the recovered clock
// - loss output high and status bit one while loss is declared
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "rld_consts.svh"
module rld_los_detect
  import rld_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // recovered line side, asynchronous
  input  wire logic        recovered_clock_i,
  input  wire logic        rx_pos_pulse_i,
  input  wire logic        rx_neg_pulse_i,
  input  wire logic        amp_at_declare_i,
  input  wire logic        amp_above_clear_i,
  input  wire logic        lock_loss_flag_i,
  input  wire logic        drive_monitor_flag_i,
  // configuration pins, asynchronous
  input  wire logic        host_mode_i,
  input  wire logic        mute_on_loss_pin_i,
  input  wire logic        clock_invert_pin_i,
  // terminal equipment side
  output logic             line_signal_loss_o,
  output logic             rx_positive_rail_o,
  output logic             rx_negative_rail_o,
  output logic             recovered_clock_o,
  // analog front end
  output logic             equalizer_enable_o
);

  // ------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------
  logic [9:0] async_in;
  logic [9:0] sync_in;

  assign async_in = {recovered_clock_i, rx_pos_pulse_i, rx_neg_pulse_i,
                     amp_at_declare_i, amp_above_clear_i,
                     lock_loss_flag_i, drive_monitor_flag_i,
                     host_mode_i, mute_on_loss_pin_i, clock_invert_pin_i};

  rld_sync #(
    .W (10)
  ) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (async_in),
    .sync_o    (sync_in)
  );

  wire rclk_s      = sync_in[9];
  wire pos_s       = sync_in[8];
  wire neg_s       = sync_in[7];
  wire amp_low_s   = sync_in[6];
  wire amp_high_s  = sync_in[5];
  wire lock_loss_s = sync_in[4];
  wire drv_mon_s   = sync_in[3];
  wire host_s      = sync_in[2];
  wire mute_pin_s  = sync_in[1];
  wire inv_pin_s   = sync_in[0];

  // ------------------------------------------------------------
  // unit-interval strobe from the sampled recovered clock
  // limitation: the line clock must stay well under half of clk_i
  // ------------------------------------------------------------
  logic rclk_d_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) rclk_d_r <= 1'b0;
    else            rclk_d_r <= rclk_s;
  end

  wire ui_en = rclk_s & ~rclk_d_r;

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [2:0] cr2_r;
  logic [4:1] cr3_r;
  logic       ack_r;
  logic [31:0] rdat_r;

  wire req      = wb_cyc_i & wb_stb_i & ~ack_r;
  wire hit_stat = (wb_adr_i == `RLD_ADR_STATUS);
  wire hit_cr2  = (wb_adr_i == `RLD_ADR_LOSS_CTRL);
  wire hit_cr3  = (wb_adr_i == `RLD_ADR_RXOUT_CTRL);
  wire wr_lane0 = req & wb_we_i & wb_sel_i[0];
  wire wr_cr2   = wr_lane0 & hit_cr2;
  wire wr_cr3   = wr_lane0 & hit_cr3;

  wire amp_dis  = cr2_r[`RLD_CR2_AMP_DIS];
  wire dens_dis = cr2_r[`RLD_CR2_DENS_DIS];

  logic [4:0] status;
  wire  [31:0] rd_mux = hit_stat ? {27'h0000000, status}       :
                        hit_cr2  ? {29'h0000000, cr2_r}        :
                        hit_cr3  ? {27'h0000000, cr3_r, 1'b0}  :
                                   32'h00000000;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cr2_r <= `RLD_CR2_RST;
      cr3_r <= `RLD_CR3_RST;
    end else begin
      if (wr_cr2) cr2_r <= wb_dat_i[2:0];
      if (wr_cr3) cr3_r <= wb_dat_i[4:1];
    end
  end

  // every access is answered, unmapped ones read zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r  <= req;
      if (req) rdat_r <= rd_mux;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) equalizer_enable_o <= 1'b0;
    else            equalizer_enable_o <= cr2_r[`RLD_CR2_EQ_EN];
  end

  // ------------------------------------------------------------
  // amplitude loss: comparator held for 32 UI before any change,
  // which keeps declare and clear inside the 10..255 UI window
  // ------------------------------------------------------------
  rld_alos_e  alos_state_r;
  logic [5:0] alos_cnt_r;

  wire alos_r    = (alos_state_r == ALOS_LOST);
  // hysteresis: declare and clear use different comparators
  wire alos_cond = alos_r ? amp_high_s : amp_low_s;
  wire alos_flip = alos_cond && (alos_cnt_r == `RLD_ALOS_LAST_UI);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alos_state_r <= ALOS_CLEAR;
      alos_cnt_r   <= 6'h00;
    end else if (amp_dis) begin
      alos_state_r <= ALOS_CLEAR;
      alos_cnt_r   <= 6'h00;
    end else if (ui_en) begin
      alos_cnt_r <= (!alos_cond || alos_flip) ? 6'h00
                                              : alos_cnt_r + 6'h01;
      case (alos_state_r)
        ALOS_CLEAR: if (alos_flip) alos_state_r <= ALOS_LOST;
        ALOS_LOST:  if (alos_flip) alos_state_r <= ALOS_CLEAR;
        default:    alos_state_r <= ALOS_CLEAR;
      endcase
    end
  end

  // ------------------------------------------------------------
  // density loss on the recovered bit stream
  // ------------------------------------------------------------
  logic dens_loss;

  rld_density u_density (
    .clk_i          (clk_i),
    .reset_n_i      (reset_n_i),
    .bit_en_i       (ui_en),
    .bit_one_i      (pos_s | neg_s),
    .disable_i      (dens_dis),
    .density_loss_o (dens_loss)
  );

  // ------------------------------------------------------------
  // combined loss and status
  // ------------------------------------------------------------
  logic line_loss_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) line_loss_r <= 1'b0;
    else            line_loss_r <= alos_r | dens_loss;
  end

  assign line_signal_loss_o = line_loss_r;
  assign status = {lock_loss_s, line_loss_r, alos_r, dens_loss,
                   drv_mon_s};

  // ------------------------------------------------------------
  // checker helpers: ui strobes for which a line condition held
  // ------------------------------------------------------------
  logic [7:0] low_ui_r;
  logic [7:0] high_ui_r;
  logic [7:0] zero_run_r;
  wire        bit_one = pos_s | neg_s;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_ui_r   <= 8'h00;
      high_ui_r  <= 8'h00;
      zero_run_r <= 8'h00;
    end else begin
      if (!amp_low_s || amp_dis) low_ui_r <= 8'h00;
      else if (ui_en)            low_ui_r <= rld_sat_inc8(low_ui_r);
      if (!amp_high_s || amp_dis) high_ui_r <= 8'h00;
      else if (ui_en)             high_ui_r <= rld_sat_inc8(high_ui_r);
      if (dens_dis || (ui_en && bit_one)) zero_run_r <= 8'h00;
      else if (ui_en) zero_run_r <= rld_sat_inc8(zero_run_r);
    end
  end

  // ------------------------------------------------------------
  // output stage: pin straps in hardware mode, bits in host mode
  // ------------------------------------------------------------
  wire mute_eff = host_s ? cr3_r[`RLD_CR3_MUTE] : mute_pin_s;
  wire inv_eff  = host_s ? cr3_r[`RLD_CR3_CLK_INV]
                         : inv_pin_s;
  wire muted    = mute_eff & line_loss_r;

  logic pos_r;
  logic neg_r;
  logic rclk_out_r;

  // rails launch on the sampled rising edge, so an inverted clock
  // makes the launch coincide with its falling edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pos_r <= 1'b0;
      neg_r <= 1'b0;
    end else if (ui_en) begin
      pos_r <= pos_s & ~muted;
      neg_r <= neg_s & ~muted;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) rclk_out_r <= 1'b0;
    else            rclk_out_r <= rclk_s ^ inv_eff;
  end

  assign rx_positive_rail_o = pos_r;
  assign rx_negative_rail_o = neg_r;
  assign recovered_clock_o  = rclk_out_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_loss_is_or: assert property (
    line_signal_loss_o == $past(alos_r | dens_loss))
    else $error("combined loss is not the or of both detectors");

  a_rails_muted: assert property (
    ui_en && muted |=> !rx_positive_rail_o && !rx_negative_rail_o)
    else $error("rails not forced low while muted loss");

  a_amp_disabled: assert property (
    amp_dis |=> !alos_r)
    else $error("amplitude loss declared while disabled");

  a_dens_disabled: assert property (
    dens_dis |=> !dens_loss)
    else $error("density loss declared while disabled");

  a_both_disabled: assert property (
    amp_dis && dens_dis ##1 amp_dis && dens_dis |=> !line_signal_loss_o)
    else $error("loss declared with both detectors disabled");

  a_alos_declare: assert property (
    $rose(alos_r) |-> $past(amp_low_s))
    else $error("amplitude loss set without low amplitude");

  a_alos_clear: assert property (
    $fell(alos_r) && !$past(amp_dis) |-> $past(amp_high_s))
    else $error("amplitude loss cleared below clear threshold");

  a_status_read: assert property (
    req && !wb_we_i && hit_stat
      |=> wb_ack_o && wb_dat_o[2] == $past(alos_r)
          && wb_dat_o[3] == $past(line_loss_r))
    else $error("status read does not show detector state");

  a_clock_fwd: assert property (
    recovered_clock_o == $past(rclk_s ^ inv_eff))
    else $error("recovered clock not forwarded");

  a_rail_launch: assert property (
    $changed(rx_positive_rail_o) |-> $past(ui_en))
    else $error("rail changed away from the launch edge");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  a_alos_set_ui: assert property (
    $rose(alos_r) |-> low_ui_r >= 8'h0A && low_ui_r != 8'hFF)
    else $error("amplitude loss declared outside its ui window");

  a_alos_clr_ui: assert property (
    $fell(alos_r) && !$past(amp_dis)
      |-> high_ui_r >= 8'h0A && high_ui_r != 8'hFF)
    else $error("amplitude loss cleared outside its ui window");

  a_dens_run: assert property (
    $rose(dens_loss) |-> zero_run_r >= 8'h80 && zero_run_r <= 8'hC0)
    else $error("density loss declared off the zero run length");

  a_rails_pass: assert property (
    ui_en && !muted |=> rx_positive_rail_o == $past(pos_s)
                        && rx_negative_rail_o == $past(neg_s))
    else $error("rails do not follow the received pulses");

  a_status_fields: assert property (
    req && !wb_we_i && hit_stat
      |=> wb_dat_o[4] == $past(lock_loss_s)
          && wb_dat_o[1] == $past(dens_loss)
          && wb_dat_o[0] == $past(drv_mon_s)
          && wb_dat_o[31:5] == 27'h0000000)
    else $error("status read shows wrong lock, density or monitor bits");

  c_alos_rise: cover property ($rose(alos_r));
  c_dens_cycle: cover property ($fell(dens_loss));
  c_muted_rail: cover property (ui_en && muted);
  c_inverted: cover property (inv_eff && ui_en);

endmodule : rld_los_detect

// *** tb/rld_framer.sv ***
// terminal equipment model that samples the dual rails
`timescale 1ns/1ps
module rld_framer (
  // recovered stream from the block
  input  wire logic rclk_i,
  input  wire logic inv_i,
  input  wire logic pos_i,
  input  wire logic neg_i,
  // running tallies of sampled bits and marks
  output int        n_bit_o,
  output int        n_pos_o,
  output int        n_neg_o
);
  initial begin
    n_bit_o = 0;
    n_pos_o = 0;
    n_neg_o = 0;
  end

  // sample on the edge opposite launch, half a period after it
  always @(rclk_i) begin
    if (rclk_i === inv_i) begin
      n_bit_o = n_bit_o + 1;
      n_pos_o = n_pos_o + int'(pos_i);
      n_neg_o = n_neg_o + int'(neg_i);
    end
  end
endmodule : rld_framer

// *** tb/test_rld_los_detect.sv ***
// self-checking bench of the loss supervision and output block
`timescale 1ns/1ps
`include "rld_consts.svh"
module test_rld_los_detect;
  localparam int LIMIT = 40000;
  logic        clk_i, rst_n, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic        lclk, pp, pn, adec, aclr, lol, drv;
  logic        host, mpin, ipin, inv, pol;
  logic        los, rp, rn, rco, eq;
  int          errors, n_tests, seed, ep, en, nb, np, nn;
  int          cyc_n = 0;

  rld_los_detect DUT (
    .clk_i(clk_i),
    .reset_n_i(rst_n),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .recovered_clock_i(lclk),
    .rx_pos_pulse_i(pp),
    .rx_neg_pulse_i(pn),
    .amp_at_declare_i(adec),
    .amp_above_clear_i(aclr),
    .lock_loss_flag_i(lol),
    .drive_monitor_flag_i(drv),
    .host_mode_i(host),
    .mute_on_loss_pin_i(mpin),
    .clock_invert_pin_i(ipin),
    .line_signal_loss_o(los),
    .rx_positive_rail_o(rp),
    .rx_negative_rail_o(rn),
    .recovered_clock_o(rco),
    .equalizer_enable_o(eq)
  );

  rld_framer u_frm (
    .rclk_i(rco),
    .inv_i(inv),
    .pos_i(rp),
    .neg_i(rn),
    .n_bit_o(nb),
    .n_pos_o(np),
    .n_neg_o(nn)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // a hung handshake ends here rather than running forever
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == LIMIT) begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(q, e);
  endtask : rd

  task automatic st;
    repeat (5) @(posedge clk_i);
  endtask : st

  // one unit interval: data set while the line clock is low
  task automatic ui(input logic p, input logic n);
    lclk <= 1'b0;
    pp <= p;
    pn <= n;
    repeat (4) @(posedge clk_i);
    lclk <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : ui

  // kind 0 zeros, 1 all marks, 2 random, 3 one mark in four
  task automatic run(input int n, input int kind);
    logic b, p;
    for (int i = 0; i < n; i++) begin
      b = kind == 1 || (kind == 2 && $random(seed) % 2 != 0) ||
          (kind == 3 && i % 4 == 0);
      p = b & ~pol;
      ep += p;
      en += b ^ p;
      pol ^= b;
      ui(p, b ^ p);
    end
  endtask : run

  // zero flushes around the window: each bit is sampled one UI late
  task automatic win(input int n, input int kind, input logic mute);
    int b0, p0, n0;
    ui(1'b0, 1'b0);
    b0 = nb;
    p0 = np;
    n0 = nn;
    {ep, en} = '0;
    run(n, kind);
    ui(1'b0, 1'b0);
    chk(nb - b0, n + 1);
    chk(np - p0, mute ? 0 : ep);
    chk(nn - n0, mute ? 0 : en);
  endtask : win

  initial begin
    {rst_n, cyc, stb, we, lclk, pp, pn, adec, aclr} = '0;
    {lol, drv, mpin, ipin, inv, pol} = '0;
    host = 1'b1;
    adr = '0;
    sel = '0;
    wdat = '0;
    {errors, n_tests, ep, en} = '0;
    seed = 44;
    repeat (6) @(posedge clk_i);
    rst_n <= 1'b1;
    @(posedge clk_i);
    rd(`RLD_ADR_LOSS_CTRL, 32'h0);
    rd(`RLD_ADR_RXOUT_CTRL, 32'h0);
    wr(`RLD_ADR_STATUS, 32'h1F);
    rd(`RLD_ADR_STATUS, 32'h0);
    wr(`RLD_ADR_RXOUT_CTRL, 32'hFFFFFFFF);
    rd(`RLD_ADR_RXOUT_CTRL, 32'h1E);
    bus(1'b1, `RLD_ADR_LOSS_CTRL, 32'h7, 4'hE);
    rd(`RLD_ADR_LOSS_CTRL, 32'h0);
    wr(8'h0C, 32'h1F);
    rd(8'h0C, 32'h0);
    wr(`RLD_ADR_LOSS_CTRL, 32'h1F);
    rd(`RLD_ADR_LOSS_CTRL, 32'h7);
    wr(`RLD_ADR_LOSS_CTRL, 32'h1);
    wr(`RLD_ADR_RXOUT_CTRL, 32'h0);
    chk(eq, 1'b1);
    win(48, 2, 1'b0);
    run(1, 1);
    run(120, 0);
    run(1, 1);
    run(127, 0);
    st();
    chk(los, 1'b0);
    run(65, 0);
    st();
    chk(los, 1'b1);
    rd(`RLD_ADR_STATUS, 32'h0A);
    wr(`RLD_ADR_RXOUT_CTRL, 32'h8);
    win(20, 1, 1'b1);
    run(160, 3);
    chk(los, 1'b1);
    run(96, 1);
    chk(los, 1'b1);
    run(64, 1);
    st();
    chk(los, 1'b0);
    win(30, 2, 1'b0);
    wr(`RLD_ADR_RXOUT_CTRL, 32'h2);
    inv <= 1'b1;
    st();
    chk(rco, !lclk);
    win(20, 2, 1'b0);
    adec <= 1'b1;
    run(9, 1);
    chk(los, 1'b0);
    run(31, 1);
    st();
    chk(los, 1'b1);
    rd(`RLD_ADR_STATUS, 32'h0C);
    adec <= 1'b0;
    run(40, 1);
    chk(los, 1'b1);
    aclr <= 1'b1;
    run(9, 1);
    chk(los, 1'b1);
    run(31, 1);
    st();
    chk(los, 1'b0);
    lol <= 1'b1;
    drv <= 1'b1;
    st();
    rd(`RLD_ADR_STATUS, 32'h11);
    {lol, drv, aclr} <= '0;
    wr(`RLD_ADR_LOSS_CTRL, 32'h7);
    adec <= 1'b1;
    run(200, 0);
    chk(los, 1'b0);
    rd(`RLD_ADR_STATUS, 32'h0);
    wr(`RLD_ADR_LOSS_CTRL, 32'h5);
    run(200, 0);
    st();
    rd(`RLD_ADR_STATUS, 32'h0A);
    wr(`RLD_ADR_LOSS_CTRL, 32'h3);
    run(40, 0);
    st();
    rd(`RLD_ADR_STATUS, 32'h0C);
    adec <= 1'b0;
    aclr <= 1'b1;
    wr(`RLD_ADR_LOSS_CTRL, 32'h1);
    run(40, 1);
    st();
    chk(los, 1'b0);
    aclr <= 1'b0;
    // pin configuration: register bits must no longer matter
    host <= 1'b0;
    mpin <= 1'b1;
    ipin <= 1'b1;
    wr(`RLD_ADR_RXOUT_CTRL, 32'h0);
    st();
    chk(rco, !lclk);
    win(30, 2, 1'b0);
    run(200, 0);
    win(20, 1, 1'b1);
    mpin <= 1'b0;
    ipin <= 1'b0;
    inv <= 1'b0;
    st();
    chk(rco, lclk);
    win(20, 1, 1'b0);
    print_verdict();
  end
endmodule : test_rld_los_detect
